// ==== hdl/bpb_pkg.sv ====
// package of constants for the board peripheral bus decode block
// assumes a 32-bit peripheral bus address sampled on SYS_CLK
`default_nettype none
package bpb_pkg;
    // ****************************************
    // bus and clock
    // ****************************************
    localparam int           SYS_CLK_MHZ     = 200;
    localparam int           PB_CLK_MHZ      = 66;
    localparam int           PB_ADDR_W       = 32;
    localparam int           PB_DATA_W       = 16;
    localparam int           REG_W           = 8;
    // ****************************************
    // address windows, upper 16 address bits
    // ****************************************
    localparam logic [15:0]  WIN_HEX_LEFT    = 16'hCE84;
    localparam logic [15:0]  WIN_HEX_RIGHT   = 16'hCE85;
    localparam logic [15:0]  WIN_BUZZER      = 16'hCE86;
    localparam logic [15:0]  WIN_BBRAM       = 16'hCE87;
    localparam logic [15:0]  WIN_BATTERY     = 16'hCE88;
    localparam logic [15:0]  WIN_ROTARY      = 16'hCE89;
    // ****************************************
    // flash and battery backed ram geometry
    // ****************************************
    localparam logic [31:0]  FLASH_BASE      = 32'hF000_0000;
    localparam int           FLASH_BYTES_MB  = 8;
    localparam int           FLASH_BYTE_AW   = 23;
    localparam int           FLASH_WORD_AW   = FLASH_BYTE_AW - 1;
    localparam int           FLASH_DATA_W    = 16;
    localparam int           BBRAM_AW        = 15;
    localparam int           BBRAM_DATA_W    = 8;
    // ****************************************
    // battery status byte fields, then buzzer, rotary and hex display constants
    // ****************************************
    localparam int           BATT_PRESENT_BIT    = 0;
    localparam int           BATT_CHARGED_BIT    = 1;
    localparam int           BATT_DISCHARGED_BIT = 2;
    localparam int           BATT_ENABLE_BIT     = 3;
    localparam logic         BATT_ENABLE_RESET   = 1'b1;
    localparam int           BUZZER_ON_BIT       = 0;
    localparam int           ROTARY_W            = 4;
    localparam logic [7:0]   HEX_RESET           = 8'h00;
endpackage : bpb_pkg
`default_nettype wire

// ==== hdl/bpb_irq_route.sv ====
// fixed routing of external interrupt lines to the processor inputs
// assumes all lines active low and already synchronous
`default_nettype none
module bpb_irq_route (
    input  wire logic [3:0] slot_irq_n,
    input  wire logic [3:0] edge_irq_n,
    input  wire logic       temp_alert_n,
    output logic      [3:0] secondary_irq_n,
    output logic      [3:0] primary_irq_n,
    output logic            high_priority_irq_n
);
    // ****************************************
    // routing, index 0..3 = letters a..d
    // ****************************************
    assign secondary_irq_n     = {slot_irq_n[0], slot_irq_n[3:1]};
    assign primary_irq_n       = edge_irq_n;
    assign high_priority_irq_n = temp_alert_n;
endmodule // bpb_irq_route
`default_nettype wire

// ==== hdl/bpb_reset_ctl.sv ====
// board reset distribution, debug reset line and memory clock enable hold
// assumes reset inputs synchronous to clk
`default_nettype none
module bpb_reset_ctl (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic primary_bus_reset_n,
    input  wire logic debug_system_reset_n_i,
    input  wire logic cke_from_cpu,
    output logic      board_reset_n,
    output logic      debug_system_reset_n_o,
    output logic      debug_system_reset_n_oe,
    output logic      memory_clock_enable
);
    logic cke_hold;

    // ****************************************
    // board reset
    // ****************************************
    assign debug_system_reset_n_o = 1'b0;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            debug_system_reset_n_oe <= 1'b0;
        end else begin
            debug_system_reset_n_oe <= ~primary_bus_reset_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            board_reset_n <= 1'b0;
        end else begin
            // own drive of the debug line must not latch the reset on
            board_reset_n <= primary_bus_reset_n
                           & (debug_system_reset_n_i | debug_system_reset_n_oe);
        end
    end

    // ****************************************
    // memory clock enable hold
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cke_hold <= 1'b1;
        end else if (primary_bus_reset_n) begin
            cke_hold <= 1'b0;
        end else if (!cke_from_cpu) begin
            cke_hold <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            memory_clock_enable <= 1'b0;
        end else begin
            memory_clock_enable <= cke_from_cpu & ~cke_hold & primary_bus_reset_n;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_board_rst_primary: assert property (@(posedge clk) disable iff (!rst_b)
        !primary_bus_reset_n |=> !board_reset_n)
        else $error("board reset not asserted after primary reset");
    a_debug_forces_rst: assert property (@(posedge clk) disable iff (!rst_b)
        (!debug_system_reset_n_i && !debug_system_reset_n_oe) |=> !board_reset_n)
        else $error("debugger reset did not reset the board");
    a_cke_held_low: assert property (@(posedge clk) disable iff (!rst_b)
        (!primary_bus_reset_n && !cke_from_cpu) ##1 !primary_bus_reset_n [*2]
        |-> !memory_clock_enable)
        else $error("clock enable released during primary reset");
    a_cke_release: assert property (@(posedge clk) disable iff (!rst_b)
        (primary_bus_reset_n && cke_from_cpu) [*2] |=> memory_clock_enable)
        else $error("clock enable not released after primary reset");
endmodule // bpb_reset_ctl
`default_nettype wire

// ==== hdl/bpb_top.sv ====
// peripheral bus decode, board registers, interrupt routing and resets
// assumes bus requests are one-cycle pulses synchronous to SYS_CLK
`default_nettype none

// Summary of operation
// - bus carries 8 or 16 bit data, board bus clock is 66 MHz
// - flash attaches with a 16-bit data path, word addressed
// - flash window spans 8 MB
// - battery backed ram, 32K by 8, selected at CE870000-CE87FFFF
// - buzzer control register selected at CE860000-CE86FFFF
// - buzzer follows the value last written to its control register
// - left hex display written through CE840000-CE84FFFF
// - right hex display written through CE850000-CE85FFFF
// - rotary switch read returns its 4-bit position
// - battery status bit 0 read-only, battery present
// - battery status bit 1 read-only, battery fully charged
// - battery status bit 2 read-only, battery fully discharged
// - battery status bit 3 read-write, enables battery backup
// - secondary interrupts a..d come from slot b,c,d,a
// - primary interrupts a..d come from same-lettered card edge lines
// - high-priority interrupt comes from temperature sensor alert
// - primary reset, also at power-up, resets the whole board
// - debug reset line is two-way and forces a full board reset
// - memory clock enable held low through primary reset, then released
module bpb_top #(
    parameter logic [31:0] FLASH_BASE_ADDR = bpb_pkg::FLASH_BASE
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        PB_REQ,
    input  wire logic        PB_WE,
    input  wire logic        PB_WIDTH16,
    input  wire logic [31:0] PB_ADDR,
    input  wire logic [15:0] PB_WDATA,
    output logic             PB_ACK,
    output logic      [15:0] PB_RDATA,
    output logic             FLASH_CS_N,
    output logic      [21:0] FLASH_ADDR,
    output logic             BBRAM_CS_N,
    output logic      [14:0] BBRAM_ADDR,
    output logic             BUZZER_ON,
    output logic      [7:0]  HEX_LEFT,
    output logic      [7:0]  HEX_RIGHT,
    input  wire logic [3:0]  ROTARY_SW,
    input  wire logic        BATT_PRESENT,
    input  wire logic        BATT_CHARGED,
    input  wire logic        BATT_DISCHARGED,
    output logic             BATT_BACKUP_EN,
    input  wire logic [3:0]  SLOT_IRQ_N,
    input  wire logic [3:0]  EDGE_IRQ_N,
    input  wire logic        TEMP_ALERT_N,
    output logic             SECONDARY_IRQ_A_N,
    output logic             SECONDARY_IRQ_B_N,
    output logic             SECONDARY_IRQ_C_N,
    output logic             SECONDARY_IRQ_D_N,
    output logic             PRIMARY_IRQ_A_N,
    output logic             PRIMARY_IRQ_B_N,
    output logic             PRIMARY_IRQ_C_N,
    output logic             PRIMARY_IRQ_D_N,
    output logic             HIGH_PRIORITY_IRQ_N,
    input  wire logic        PRIMARY_BUS_RESET_N,
    input  wire logic        DEBUG_SYSTEM_RESET_N_I,
    output logic             DEBUG_SYSTEM_RESET_N_O,
    output logic             DEBUG_SYSTEM_RESET_N_OE,
    output logic             BOARD_RESET_N,
    input  wire logic        CKE_FROM_CPU,
    output logic             MEMORY_CLOCK_ENABLE
);
    // ****************************************
    // decode
    // ****************************************
    function automatic logic in_window(input logic [31:0] addr, input logic [15:0] base);
        in_window = (addr[31:16] == base);
    endfunction

    logic       hit_flash;
    logic       hit_bbram;
    logic       hit_hex_l;
    logic       hit_hex_r;
    logic       hit_buzz;
    logic       hit_batt;
    logic       hit_rot;
    logic       local_req;
    logic       wr_req;
    logic [7:0] wbyte;
    logic [7:0] batt_status;
    logic [7:0] next_rbyte;
    logic       buzzer_reg;
    logic       batt_en;

    assign hit_flash = (PB_ADDR[31:bpb_pkg::FLASH_BYTE_AW]
                        == FLASH_BASE_ADDR[31:bpb_pkg::FLASH_BYTE_AW]);
    assign hit_bbram = in_window(PB_ADDR, bpb_pkg::WIN_BBRAM);
    assign hit_buzz  = in_window(PB_ADDR, bpb_pkg::WIN_BUZZER);
    assign hit_hex_l = in_window(PB_ADDR, bpb_pkg::WIN_HEX_LEFT);
    assign hit_hex_r = in_window(PB_ADDR, bpb_pkg::WIN_HEX_RIGHT);
    assign hit_batt  = in_window(PB_ADDR, bpb_pkg::WIN_BATTERY);
    assign hit_rot   = in_window(PB_ADDR, bpb_pkg::WIN_ROTARY);
    assign local_req = PB_REQ & ~hit_flash & ~hit_bbram;
    assign wr_req    = local_req & PB_WE;
    // board registers are byte wide in either bus width
    assign wbyte     = PB_WDATA[7:0];

    // ****************************************
    // external chip selects
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            FLASH_CS_N <= 1'b1;
            FLASH_ADDR <= '0;
        end else begin
            FLASH_CS_N <= ~(PB_REQ & hit_flash);
            FLASH_ADDR <= PB_ADDR[bpb_pkg::FLASH_BYTE_AW-1:1];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            BBRAM_CS_N <= 1'b1;
            BBRAM_ADDR <= '0;
        end else begin
            BBRAM_CS_N <= ~(PB_REQ & hit_bbram);
            BBRAM_ADDR <= PB_ADDR[bpb_pkg::BBRAM_AW-1:0];
        end
    end

    // ****************************************
    // board registers
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            buzzer_reg <= 1'b0;
        end else if (wr_req && hit_buzz) begin
            buzzer_reg <= wbyte[bpb_pkg::BUZZER_ON_BIT];
        end
    end
    assign BUZZER_ON = buzzer_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            HEX_LEFT <= bpb_pkg::HEX_RESET;
        end else if (wr_req && hit_hex_l) begin
            HEX_LEFT <= wbyte;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            HEX_RIGHT <= bpb_pkg::HEX_RESET;
        end else if (wr_req && hit_hex_r) begin
            HEX_RIGHT <= wbyte;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            batt_en <= bpb_pkg::BATT_ENABLE_RESET;
        end else if (wr_req && hit_batt) begin
            batt_en <= wbyte[bpb_pkg::BATT_ENABLE_BIT];
        end
    end
    assign BATT_BACKUP_EN = batt_en;

    always_comb begin
        batt_status                                 = 8'h00;
        batt_status[bpb_pkg::BATT_PRESENT_BIT]      = BATT_PRESENT;
        batt_status[bpb_pkg::BATT_CHARGED_BIT]      = BATT_CHARGED;
        batt_status[bpb_pkg::BATT_DISCHARGED_BIT]   = BATT_DISCHARGED;
        batt_status[bpb_pkg::BATT_ENABLE_BIT]       = batt_en;
    end

    // ****************************************
    // read path and answer
    // ****************************************
    always_comb begin
        next_rbyte = 8'h00;
        if (hit_buzz) begin
            next_rbyte = {7'h00, buzzer_reg};
        end else if (hit_hex_l) begin
            next_rbyte = HEX_LEFT;
        end else if (hit_hex_r) begin
            next_rbyte = HEX_RIGHT;
        end else if (hit_batt) begin
            next_rbyte = batt_status;
        end else if (hit_rot) begin
            next_rbyte = {4'h0, ROTARY_SW};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            PB_ACK   <= 1'b0;
            PB_RDATA <= 16'h0000;
        end else begin
            PB_ACK <= local_req;
            if (local_req && !PB_WE) begin
                // upper lane is zero in either width
                PB_RDATA <= {8'h00, next_rbyte};
            end
        end
    end

    // ****************************************
    // interrupts and resets
    // ****************************************
    logic [3:0] sec_irq_n;
    logic [3:0] pri_irq_n;

    bpb_irq_route u_irq (
        .slot_irq_n          (SLOT_IRQ_N),
        .edge_irq_n          (EDGE_IRQ_N),
        .temp_alert_n        (TEMP_ALERT_N),
        .secondary_irq_n     (sec_irq_n),
        .primary_irq_n       (pri_irq_n),
        .high_priority_irq_n (HIGH_PRIORITY_IRQ_N)
    );
    assign SECONDARY_IRQ_A_N = sec_irq_n[0];
    assign SECONDARY_IRQ_B_N = sec_irq_n[1];
    assign SECONDARY_IRQ_C_N = sec_irq_n[2];
    assign SECONDARY_IRQ_D_N = sec_irq_n[3];
    assign PRIMARY_IRQ_A_N   = pri_irq_n[0];
    assign PRIMARY_IRQ_B_N   = pri_irq_n[1];
    assign PRIMARY_IRQ_C_N   = pri_irq_n[2];
    assign PRIMARY_IRQ_D_N   = pri_irq_n[3];

    bpb_reset_ctl u_rst (
        .clk                     (SYS_CLK),
        .rst_b                   (RST_B),
        .primary_bus_reset_n     (PRIMARY_BUS_RESET_N),
        .debug_system_reset_n_i  (DEBUG_SYSTEM_RESET_N_I),
        .cke_from_cpu            (CKE_FROM_CPU),
        .board_reset_n           (BOARD_RESET_N),
        .debug_system_reset_n_o  (DEBUG_SYSTEM_RESET_N_O),
        .debug_system_reset_n_oe (DEBUG_SYSTEM_RESET_N_OE),
        .memory_clock_enable     (MEMORY_CLOCK_ENABLE)
    );

    // ****************************************
    // checks
    // ****************************************
    sequence s_local_read;
        PB_REQ && !PB_WE && !hit_flash && !hit_bbram;
    endsequence

    a_flash_word_addr: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PB_REQ && hit_flash |=> !FLASH_CS_N && FLASH_ADDR == $past(PB_ADDR[22:1]))
        else $error("flash select or word address wrong");
    a_bbram_select: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PB_REQ && PB_ADDR[31:16] == 16'hCE87 |=> !BBRAM_CS_N && BBRAM_ADDR == $past(PB_ADDR[14:0]))
        else $error("battery backed ram not selected");
    a_buzzer_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PB_REQ && PB_WE && PB_ADDR[31:16] == 16'hCE86 |=> BUZZER_ON == $past(PB_WDATA[0]))
        else $error("buzzer does not follow write");
    a_hex_left_only: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PB_REQ && PB_WE && PB_ADDR[31:16] == 16'hCE84 |=> HEX_LEFT == $past(PB_WDATA[7:0]) && $stable(HEX_RIGHT))
        else $error("left display write wrong");
    a_hex_right_only: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        PB_REQ && PB_WE && PB_ADDR[31:16] == 16'hCE85 |=> HEX_RIGHT == $past(PB_WDATA[7:0]) && $stable(HEX_LEFT))
        else $error("right display write wrong");
    a_rotary_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_local_read ##0 PB_ADDR[31:16] == bpb_pkg::WIN_ROTARY |=> PB_ACK && PB_RDATA == {12'h000, $past(ROTARY_SW)})
        else $error("rotary read wrong");
    a_batt_status_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_local_read ##0 hit_batt |=> PB_RDATA[2:0] == $past({BATT_DISCHARGED, BATT_CHARGED, BATT_PRESENT})
        && PB_RDATA[15:4] == 12'h000)
        else $error("battery status read wrong");
    a_batt_enable_wr: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        wr_req && hit_batt |=> BATT_BACKUP_EN == $past(PB_WDATA[3]))
        else $error("battery enable write wrong");
    a_batt_enable_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        !(wr_req && hit_batt) |=> $stable(BATT_BACKUP_EN))
        else $error("battery enable changed without a write");
    a_upper_lane_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_local_read ##0 !PB_WIDTH16 |=> PB_RDATA[15:8] == 8'h00)
        else $error("upper read lane not zero in byte mode");
    a_irq_rotation: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        SECONDARY_IRQ_A_N == SLOT_IRQ_N[1] && SECONDARY_IRQ_D_N == SLOT_IRQ_N[0] && PRIMARY_IRQ_C_N == EDGE_IRQ_N[2])
        else $error("interrupt routing wrong");
endmodule // bpb_top
`default_nettype wire

// ==== verif/bpb_pb_master.sv ====
// peripheral bus master model standing in for the i/o processor
// assumes tasks are called from the bench; signals change at the falling edge
`default_nettype none
module bpb_pb_master (
    input  wire logic        clk,
    input  wire logic        primary_bus_reset_n_n,
    output logic             req,
    output logic             we,
    output logic             w16,
    output logic      [31:0] addr,
    output logic      [15:0] wdata,
    output logic             cke
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // self-refresh and bus cycles
    // ****************************************
    // self-refresh drops the clock enable while primary reset is active
    assign cke = primary_bus_reset_n_n;
    initial begin
        req = 1'b0;
        we = 1'b0;
        w16 = 1'b0;
        addr = 32'h0;
        wdata = 16'h0;
    end
    // one-cycle request pulse; 8 or 16 bit width chosen per access
    task automatic op(input logic w, input logic [31:0] a, input logic [15:0] d, input logic wide);
        @(negedge clk);
        req = 1'b1;
        we = w;
        w16 = wide;
        addr = a;
        wdata = d;
    endtask
    // released lines show the inverse of the last value
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk);
            req = 1'b0;
            addr = ~addr;
            wdata = ~wdata;
        end
    endtask
endmodule // bpb_pb_master
`default_nettype wire

// ==== verif/bpb_top_tb.sv ====
// self-checking bench for the board peripheral bus decode block
// assumes bpb_top and the bus master model; reads are scored from a queue
`default_nettype none
module bpb_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req, we, w16, cke, pb_ack, flash_cs_n, bbram_cs_n, buzzer_on, batt_en;
    logic [31:0] addr;
    logic [15:0] wdata, rdata;
    logic [21:0] flash_addr;
    logic [14:0] bbram_addr;
    logic [7:0]  hex_l, hex_r;
    logic [3:0]  rot, slot, edge_n, sec, pri;
    logic [2:0]  batt;
    logic        temp_n, hp_n, primary_bus_reset_n_n, dbg_ext_n = 1'b1, dbg_o, dbg_oe, board_rst_n, mce;
    logic        dbg_wire;
    logic [16:0] exp_q[$];
    logic [31:0] rnd = 32'hB493;
    int          n_mismatch = 0;
    int          checks_done = 0;
    // open-drain debug reset line with pull-up
    assign dbg_wire = (dbg_oe ? dbg_o : 1'b1) & dbg_ext_n;
    always #2.5 sys_clk = ~sys_clk;
    bpb_pb_master bpb_pb_master_inst (.clk(sys_clk), .primary_bus_reset_n_n(primary_bus_reset_n_n), .req(req), .we(we), .w16(w16),
        .addr(addr), .wdata(wdata), .cke(cke));
    bpb_top bpb_top_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .PB_REQ(req), .PB_WE(we), .PB_WIDTH16(w16),
        .PB_ADDR(addr), .PB_WDATA(wdata), .PB_ACK(pb_ack), .PB_RDATA(rdata), .FLASH_CS_N(flash_cs_n),
        .FLASH_ADDR(flash_addr), .BBRAM_CS_N(bbram_cs_n), .BBRAM_ADDR(bbram_addr), .BUZZER_ON(buzzer_on),
        .HEX_LEFT(hex_l), .HEX_RIGHT(hex_r), .ROTARY_SW(rot), .BATT_PRESENT(batt[0]), .BATT_CHARGED(batt[1]),
        .BATT_DISCHARGED(batt[2]), .BATT_BACKUP_EN(batt_en), .SLOT_IRQ_N(slot), .EDGE_IRQ_N(edge_n),
        .TEMP_ALERT_N(temp_n), .SECONDARY_IRQ_A_N(sec[3]), .SECONDARY_IRQ_B_N(sec[2]),
        .SECONDARY_IRQ_C_N(sec[1]), .SECONDARY_IRQ_D_N(sec[0]), .PRIMARY_IRQ_A_N(pri[3]),
        .PRIMARY_IRQ_B_N(pri[2]), .PRIMARY_IRQ_C_N(pri[1]), .PRIMARY_IRQ_D_N(pri[0]),
        .HIGH_PRIORITY_IRQ_N(hp_n), .PRIMARY_BUS_RESET_N(primary_bus_reset_n_n), .DEBUG_SYSTEM_RESET_N_I(dbg_wire),
        .DEBUG_SYSTEM_RESET_N_O(dbg_o), .DEBUG_SYSTEM_RESET_N_OE(dbg_oe), .BOARD_RESET_N(board_rst_n),
        .CKE_FROM_CPU(cke), .MEMORY_CLOCK_ENABLE(mce));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_mismatch++;
            $display("FAIL %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        exp_q.push_back({1'b0, 16'h0});
        bpb_pb_master_inst.op(1'b1, a, d, rnd[0]);
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        exp_q.push_back({1'b1, e});
        bpb_pb_master_inst.op(1'b0, a, 16'h0, rnd[1]);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // each acknowledge takes the oldest note; flash and ram never acknowledge
    always @(negedge sys_clk) begin
        if (pb_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else if (exp_q[0][16]) begin
                check({16'h0, rdata}, {16'h0, exp_q[0][15:0]});
                void'(exp_q.pop_front());
            end else begin
                void'(exp_q.pop_front());
            end
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0] d, e;
        logic [31:0] a;
        rot = 4'h0;
        slot = 4'hF;
        edge_n = 4'hF;
        batt = 3'h0;
        temp_n = 1'b1;
        primary_bus_reset_n_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        check(board_rst_n, 1'b0);
        rst_b = 1'b1;
        @(negedge sys_clk);
        check({buzzer_on, hex_l, hex_r, batt_en}, {1'b0, 16'h0, 1'b1});
        $display("test reset done");
        d = 8'(xs());
        e = 8'(xs());
        wr(32'hCE84FFFF, {8'hA5, d});
        wr(32'hCE850000, {8'h5A, e});
        rd(32'hCE840000, {8'h0, d});
        bpb_pb_master_inst.idle(1);
        check({hex_l, hex_r}, {d, e});
        wr(32'hCE86FFFF, 16'h0001);
        bpb_pb_master_inst.idle(1);
        check(buzzer_on, 1'b1);
        wr(32'hCE85FFFF, 16'h0000);
        wr(32'hCE860000, 16'hFFFE);
        bpb_pb_master_inst.idle(1);
        check({buzzer_on, hex_r}, {1'b0, 8'h00});
        $display("test display and buzzer done");
        for (int i = 0; i < 16; i++) begin
            rot = i[3:0];
            rd({16'hCE89, 16'(xs())}, {12'h0, i[3:0]});
            bpb_pb_master_inst.idle(1);
        end
        for (int i = 0; i < 8; i++) begin
            batt = i[2:0];
            d = 8'(xs());
            wr(32'hCE880000, {8'hFF, 4'hF, d[0], 3'h7});
            rd(32'hCE880000, {12'h0, d[0], i[2:0]});
            bpb_pb_master_inst.idle(1);
            check(batt_en, d[0]);
        end
        wr(32'hCE8A0000, 16'hFFFF);
        rd(32'hCE8A0000, 16'h0000);
        rd(32'hCE830000, 16'h0000);
        bpb_pb_master_inst.idle(1);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            a = (i < 2) ? 32'hF07FFFFE - i * 32'h7FFFFE : 32'hF0800000 + i;
            // just outside the flash window the read is unmapped and answers zero
            if (i >= 2) exp_q.push_back({1'b1, 16'h0});
            bpb_pb_master_inst.op(1'b0, a, 16'h0, 1'b1);
            @(posedge sys_clk);
            #1;
            check(flash_cs_n, i >= 2);
            if (i < 2) check(flash_addr, a[22:1]);
            bpb_pb_master_inst.idle(1);
        end
        for (int i = 0; i < 3; i++) begin
            a = {16'hCE86 + i[15:0], 16'(xs())};
            bpb_pb_master_inst.op(i[0], a, 16'h0, 1'b0);
            if (i != 1) exp_q.push_back({i == 0, 16'h0});
            @(posedge sys_clk);
            #1;
            check(bbram_cs_n, i != 1);
            if (i == 1) check(bbram_addr, a[14:0]);
            bpb_pb_master_inst.idle(1);
        end
        $display("test chip selects done");
        repeat (8) begin
            @(negedge sys_clk);
            {slot, edge_n, temp_n} = 9'(xs());
            #1;
            check({sec, pri, hp_n}, {slot[1], slot[2], slot[3], slot[0], edge_n[0], edge_n[1], edge_n[2],
                edge_n[3], temp_n});
        end
        $display("test interrupts done");
        @(negedge sys_clk);
        primary_bus_reset_n_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({board_rst_n, dbg_oe, dbg_o, mce}, 4'b0100);
        primary_bus_reset_n_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        check({board_rst_n, dbg_oe, mce}, 3'b101);
        dbg_ext_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check({board_rst_n, dbg_oe}, 2'b00);
        dbg_ext_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(board_rst_n, 1'b1);
        $display("test resets done");
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge sys_clk);
        check(exp_q.size(), 0);
        stop_test();
    end
endmodule // bpb_top_tb
`default_nettype wire
